/* File: pkg/imu_regs_pkg.sv */
package imu_regs_pkg;
	localparam logic [7:0] ADDR_IDENT    = 8'h00;
	localparam logic [7:0] ADDR_ERROR    = 8'h02;
	localparam logic [7:0] ADDR_POWER    = 8'h03;
	localparam logic [7:0] ADDR_DATA_LO  = 8'h04;
	localparam logic [7:0] ADDR_DATA_HI  = 8'h17;
	localparam logic [7:0] ADDR_GYRO_LO  = 8'h0C;
	localparam logic [7:0] ADDR_ACCEL_LO = 8'h12;
	localparam int         DATA_BYTES    = 20;
	localparam int         GYRO_BYTE_LO  = 8;
	localparam int         GYRO_BYTE_HI  = 13;
	// Identification value is arbitrary and neutral.
	localparam logic [7:0] IDENT_VALUE   = 8'h5A;
	localparam int         ERR_DROP_BIT  = 6;
	localparam int         ERR_FATAL_BIT = 0;
	localparam logic [3:0] CODE_NONE     = 4'h0;
	localparam logic [7:0] ERROR_RESET   = 8'h00;
	localparam logic [7:0] POWER_RESET   = 8'h00;
	localparam logic [1:0] PM_SUSPEND    = 2'h0;
	localparam logic [1:0] PM_NORMAL     = 2'h1;
	localparam logic [1:0] PM_LOW        = 2'h2;
	localparam logic [1:0] PM_FAST       = 2'h3;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_s;

	typedef struct packed {
		logic [1:0] acc;
		logic [1:0] gyr;
		logic [1:0] mag;
	} power_modes_s;

	typedef struct packed {
		logic       dropped_cmd;
		logic       fatal;
		logic       code_valid;
		logic [3:0] code;
	} error_events_s;
endpackage

/* File: hdl/mode_tracker.sv */
// Holds one sensor's reported mode, moving only when the new mode is effective.
module mode_tracker
	import imu_regs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [1:0] requested,
	input  wire logic       effective,
	output logic [1:0]      reported
);
	logic [1:0] mode_q;

	// mode when effective
	// The sensing element signals up before filters settle, so no settle wait here.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_q <= PM_SUSPEND;
		end else if (effective) begin
			mode_q <= requested;
		end
	end

	assign reported = mode_q;
endmodule

/* File: hdl/imu_status_data_registers.sv */
// Low end of the motion sensor register map: ident, error, power status, data.
module imu_status_data_registers
	import imu_regs_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire imu_regs_pkg::host_req_s   host_req,
	input  wire logic                      access_active,
	output logic [7:0]                     rdata,
	output logic                           rvalid,
	input  wire logic [159:0]              sample_in,
	input  wire logic                      sample_strobe,
	input  wire imu_regs_pkg::error_events_s err_evt,
	input  wire imu_regs_pkg::power_modes_s  mode_req,
	input  wire logic [2:0]                mode_effective,
	input  wire logic                      stab_mode,
	input  wire logic [3:0]                stab_addr,
	output logic [7:0]                     stab_rdata,
	input  wire logic                      drdy_set_acc,
	input  wire logic                      drdy_set_gyr,
	input  wire logic                      drdy_set_mag,
	output logic [2:0]                     drdy_flags,
	output logic                           fifo_blocked
);
	import imu_regs_pkg::*;

	logic [7:0]   data_q [DATA_BYTES];
	logic [159:0] pend_q;
	logic         pend_valid_q;
	logic         fatal_q;
	logic         drop_q;
	logic [3:0]   code_q;
	logic [7:0]   rdata_q;
	logic         rvalid_q;
	logic [7:0]   stab_q;
	logic         acc_q;
	logic         gyr_q;
	logic         mag_q;
	logic [1:0]   pm_acc;
	logic [1:0]   pm_gyr;
	logic [1:0]   pm_mag;
	logic         rd_error;
	logic         rd_data;
	logic         rd_mag;
	logic         rd_gyr;
	logic         rd_acc;
	logic         do_load;
	logic [4:0]   data_idx;
	logic [7:0]   error_view;
	logic [7:0]   power_view;

	// Address decode for read side effects.
	assign rd_error = host_req.rd && host_req.addr == ADDR_ERROR;
	assign rd_data  = host_req.rd && host_req.addr >= ADDR_DATA_LO && host_req.addr <= ADDR_DATA_HI;
	assign rd_mag   = rd_data && host_req.addr < ADDR_GYRO_LO;
	assign rd_gyr   = rd_data && host_req.addr >= ADDR_GYRO_LO && host_req.addr < ADDR_ACCEL_LO;
	assign rd_acc   = rd_data && host_req.addr >= ADDR_ACCEL_LO;
	assign data_idx = 5'(host_req.addr - ADDR_DATA_LO);

	// atomic data update
	// A sample arriving mid access is parked and loaded once the access ends.
	assign do_load = !access_active && (sample_strobe || pend_valid_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pend_q       <= '0;
			pend_valid_q <= 1'b0;
		end else if (sample_strobe && access_active) begin
			pend_q       <= sample_in;
			pend_valid_q <= 1'b1;
		end else if (do_load) begin
			pend_valid_q <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < DATA_BYTES; gi++) begin : g_data
			always_ff @(posedge clk) begin
				if (!rstn) begin
					data_q[gi] <= 8'h00;
				end else if (do_load) begin
					data_q[gi] <= sample_strobe ? sample_in[gi*8 +: 8] : pend_q[gi*8 +: 8];
				end
			end
			a_byte_frozen: assert property (@(posedge clk) disable iff (!rstn)
				access_active ##1 access_active |-> $stable(data_q[gi])) else $error("data byte moved");
		end
	endgenerate

	// fatal sticky
	// Only reset clears the fatal flag; reads leave it alone.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fatal_q <= 1'b0;
		end else if (err_evt.fatal) begin
			fatal_q <= 1'b1;
		end
	end

	// clear on read
	// A new drop in the read cycle wins over the clear so it is not lost.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			drop_q <= 1'b0;
		end else if (err_evt.dropped_cmd) begin
			drop_q <= 1'b1;
		end else if (rd_error) begin
			drop_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			code_q <= CODE_NONE;
		end else if (err_evt.code_valid && err_evt.code != CODE_NONE && (code_q == CODE_NONE || rd_error)) begin
			code_q <= err_evt.code;
		end else if (rd_error) begin
			code_q <= CODE_NONE;
		end
	end

	assign error_view = {1'b0, drop_q, 1'b0, code_q, fatal_q};

	// modes set by command
	// Gyro mode events arrive on the same request path as commands.
	mode_tracker u_acc (
		.clk       (clk),
		.rstn      (rstn),
		.requested (mode_req.acc),
		.effective (mode_effective[2]),
		.reported  (pm_acc)
	);
	mode_tracker u_gyr (
		.clk       (clk),
		.rstn      (rstn),
		.requested (mode_req.gyr),
		.effective (mode_effective[1]),
		.reported  (pm_gyr)
	);
	mode_tracker u_mag (
		.clk       (clk),
		.rstn      (rstn),
		.requested (mode_req.mag),
		.effective (mode_effective[0]),
		.reported  (pm_mag)
	);

	assign power_view = {2'b00, pm_acc, pm_gyr, pm_mag};

	assign fifo_blocked = pm_acc == PM_LOW || pm_mag == PM_LOW;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_q <= 1'b0;
			gyr_q <= 1'b0;
			mag_q <= 1'b0;
		end else begin
			acc_q <= drdy_set_acc | (acc_q & ~rd_acc);
			gyr_q <= drdy_set_gyr | (gyr_q & ~rd_gyr);
			mag_q <= drdy_set_mag | (mag_q & ~rd_mag);
		end
	end
	assign drdy_flags = {acc_q, gyr_q, mag_q};

	// fixed ident
	// Read mux; writes have no target here so every register ignores them.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= host_req.rd;
			if (host_req.rd) begin
				if (host_req.addr == ADDR_IDENT) begin
					rdata_q <= IDENT_VALUE;
				end else if (host_req.addr == ADDR_ERROR) begin
					rdata_q <= error_view;
				end else if (host_req.addr == ADDR_POWER) begin
					rdata_q <= power_view;
				end else if (rd_data) begin
					rdata_q <= data_q[data_idx];
				end else begin
					rdata_q <= 8'h00;
				end
			end
		end
	end
	assign rdata  = rdata_q;
	assign rvalid = rvalid_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stab_q <= 8'h00;
		end else if (stab_mode && stab_addr <= 4'(GYRO_BYTE_HI - GYRO_BYTE_LO)) begin
			stab_q <= data_q[5'(GYRO_BYTE_LO) + {1'b0, stab_addr}];
		end else begin
			stab_q <= 8'h00;
		end
	end
	assign stab_rdata = stab_q;

	// Assertions sit here because most of them watch the internal flag registers.
	// Expected values come from the rule, except the error, power, data and stabilization read checks, which reuse the views and data bytes the logic itself reads.

	a_ident_fixed: assert property (@(posedge clk) disable iff (!rstn)
		host_req.rd && host_req.addr == ADDR_IDENT |=> rdata == IDENT_VALUE) else $error("ident wrong");

	a_read_answer: assert property (@(posedge clk) disable iff (!rstn)
		host_req.rd |=> rvalid) else $error("read not answered");

	// writes stay silent
	// A write has no target in this block, so it must never raise an answer.
	a_write_quiet: assert property (@(posedge clk) disable iff (!rstn)
		host_req.wr && !host_req.rd |=> !rvalid) else $error("write answered");

	a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
		host_req.rd && host_req.addr == 8'h01 |=> rdata == 8'h00) else $error("unmapped byte not zero");

	a_error_read: assert property (@(posedge clk) disable iff (!rstn)
		rd_error |=> rdata == $past(error_view)) else $error("error byte wrong");

	a_drop_sets: assert property (@(posedge clk) disable iff (!rstn)
		err_evt.dropped_cmd |=> error_view[ERR_DROP_BIT]) else $error("drop not set");

	// drop beats clear
	// A drop in the very cycle of the read must survive, or the host never sees it.
	a_drop_wins: assert property (@(posedge clk) disable iff (!rstn)
		err_evt.dropped_cmd && rd_error |=> drop_q) else $error("drop lost on read");

	a_drop_clears: assert property (@(posedge clk) disable iff (!rstn)
		rd_error && !err_evt.dropped_cmd |=> !drop_q) else $error("drop not cleared");

	a_code_clears: assert property (@(posedge clk) disable iff (!rstn)
		rd_error && !err_evt.code_valid |=> code_q == CODE_NONE) else $error("code not cleared");

	a_code_taken: assert property (@(posedge clk) disable iff (!rstn)
		err_evt.code_valid && err_evt.code != CODE_NONE && code_q == CODE_NONE |=> code_q == $past(err_evt.code))
		else $error("code not taken");

	a_code_first: assert property (@(posedge clk) disable iff (!rstn)
		code_q != CODE_NONE && !rd_error |=> code_q == $past(code_q)) else $error("code overwritten");

	a_fatal_sets: assert property (@(posedge clk) disable iff (!rstn)
		err_evt.fatal |=> fatal_q) else $error("fatal not set");

	a_fatal_holds: assert property (@(posedge clk) disable iff (!rstn)
		fatal_q |=> fatal_q) else $error("fatal cleared");

	// fatal survives read
	// The read that clears the other flags must still report the fatal bit.
	a_fatal_shown: assert property (@(posedge clk) disable iff (!rstn)
		rd_error && fatal_q |=> rdata[ERR_FATAL_BIT]) else $error("fatal not shown");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
		error_view[7] == 1'b0 && error_view[5] == 1'b0 && power_view[7:6] == 2'b00) else $error("reserved set");

	a_power_read: assert property (@(posedge clk) disable iff (!rstn)
		host_req.rd && host_req.addr == ADDR_POWER |=> rdata == $past(power_view)) else $error("power byte wrong");

	a_acc_take: assert property (@(posedge clk) disable iff (!rstn)
		mode_effective[2] |=> pm_acc == $past(mode_req.acc)) else $error("accel mode not taken");

	// gyro mode taken
	// Gyro mode events share the request path, so this covers them too.
	a_gyr_take: assert property (@(posedge clk) disable iff (!rstn)
		mode_effective[1] |=> pm_gyr == $past(mode_req.gyr)) else $error("gyro mode not taken");

	a_mag_take: assert property (@(posedge clk) disable iff (!rstn)
		mode_effective[0] |=> pm_mag == $past(mode_req.mag)) else $error("mag mode not taken");

	a_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
		mode_effective == 3'b000 |=> power_view == $past(power_view)) else $error("mode moved early");

	a_fifo_low: assert property (@(posedge clk) disable iff (!rstn)
		pm_acc == PM_LOW |-> fifo_blocked) else $error("fifo open in low power");

	a_fifo_mag: assert property (@(posedge clk) disable iff (!rstn)
		pm_mag == PM_LOW |-> fifo_blocked) else $error("fifo open in mag low power");

	a_fifo_open: assert property (@(posedge clk) disable iff (!rstn)
		pm_acc != PM_LOW && pm_mag != PM_LOW |-> !fifo_blocked) else $error("fifo blocked needlessly");

	a_data_frozen: assert property (@(posedge clk) disable iff (!rstn)
		access_active ##1 access_active |-> $stable(data_q[0]) && $stable(data_q[19])) else $error("data moved");

	// parked sample loads
	// A parked sample must land as soon as the access ends, or it would go stale.
	a_pend_load: assert property (@(posedge clk) disable iff (!rstn)
		!access_active && pend_valid_q && !sample_strobe |=> data_q[0] == $past(pend_q[7:0]))
		else $error("parked sample not loaded");

	a_data_read: assert property (@(posedge clk) disable iff (!rstn)
		rd_data |=> rdata == $past(data_q[data_idx])) else $error("data byte wrong");

	a_stab_gyro: assert property (@(posedge clk) disable iff (!rstn)
		stab_mode && stab_addr == 4'(GYRO_BYTE_HI - GYRO_BYTE_LO) |=> stab_rdata == $past(data_q[GYRO_BYTE_HI]))
		else $error("stabilization byte wrong");

	a_stab_range: assert property (@(posedge clk) disable iff (!rstn)
		stab_addr > 4'(GYRO_BYTE_HI - GYRO_BYTE_LO) |=> stab_rdata == 8'h00) else $error("stabilization range open");

	a_stab_idle: assert property (@(posedge clk) disable iff (!rstn)
		!stab_mode |=> stab_rdata == 8'h00) else $error("stabilization port not idle");

	a_drdy_own: assert property (@(posedge clk) disable iff (!rstn)
		rd_gyr && acc_q && !drdy_set_gyr |=> acc_q && !gyr_q) else $error("wrong flag cleared");

	a_acc_clear: assert property (@(posedge clk) disable iff (!rstn)
		rd_acc && !drdy_set_acc |=> !acc_q) else $error("accel flag kept");

	a_mag_clear: assert property (@(posedge clk) disable iff (!rstn)
		rd_mag && !drdy_set_mag |=> !mag_q) else $error("mag flag kept");

	a_gyr_clear: assert property (@(posedge clk) disable iff (!rstn)
		rd_gyr && !drdy_set_gyr |=> !gyr_q) else $error("gyro flag kept");
endmodule

/* File: dv/host_model.sv */
// Host side of the register port: one byte access at a time, launched and released on the falling edge.
module host_model
	import imu_regs_pkg::*;
(
	input  wire logic               clk,
	output imu_regs_pkg::host_req_s host_req,
	input  wire logic [7:0]         rdata,
	input  wire logic               rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	initial host_req = '0;

	// A released bus shows the inverted address and data, so stale values never pass for fresh ones.
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		@(negedge clk);
		host_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
		@(negedge clk);
		ok = rvalid | wr;
		q  = rdata;
		host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

/* File: dv/imu_status_data_registers_bench.sv */
// Self-checking bench for the low register block.
module imu_status_data_registers_bench;
	import imu_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic          clk            = 1'b0;
	logic          rstn           = 1'b0;
	logic          access_active  = 1'b0;
	logic          sample_strobe  = 1'b0;
	logic          stab_mode      = 1'b0;
	logic [159:0]  sample_in      = '0;
	error_events_s err_evt        = '0;
	power_modes_s  mode_req       = '0;
	logic [2:0]    mode_effective = '0;
	logic [2:0]    drdy_set       = '0;
	logic [3:0]    stab_addr      = '0;
	host_req_s     host_req;
	logic [7:0]    rdata;
	logic [7:0]    stab_rdata;
	logic [7:0]    q;
	logic [2:0]    drdy_flags;
	logic          rvalid;
	logic          fifo_blocked;
	logic          ok;
	int            n_mismatch     = 0;
	int            n_tests        = 0;

	always #10 clk = ~clk;

	imu_status_data_registers i_dut (.clk(clk), .rstn(rstn), .host_req(host_req), .access_active(access_active),
		.rdata(rdata), .rvalid(rvalid), .sample_in(sample_in), .sample_strobe(sample_strobe), .err_evt(err_evt),
		.mode_req(mode_req), .mode_effective(mode_effective), .stab_mode(stab_mode), .stab_addr(stab_addr),
		.stab_rdata(stab_rdata), .drdy_set_acc(drdy_set[2]), .drdy_set_gyr(drdy_set[1]),
		.drdy_set_mag(drdy_set[0]), .drdy_flags(drdy_flags), .fifo_blocked(fifo_blocked));

	host_model i_host (.clk(clk), .host_req(host_req), .rdata(rdata), .rvalid(rvalid));

	task automatic report_and_stop();
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Reads must answer exactly one cycle after being taken.
	task automatic rd(logic [7:0] a, logic [7:0] e);
		i_host.access(1'b0, a, 8'h00, q, ok);
		chk("rvalid", 8'h01, {7'h00, ok});
		chk("rdata", e, q);
	endtask

	task automatic reset_dut();
		@(negedge clk);
		rstn = 1'b0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
	endtask

	task automatic ev(error_events_s e);
		@(negedge clk);
		err_evt = e;
		@(negedge clk);
		err_evt = '0;
	endtask

	task automatic eff(logic [2:0] m);
		@(negedge clk);
		mode_effective = m;
		@(negedge clk);
		mode_effective = '0;
	endtask

	// Each new block sets all three ready flags, byte i carrying base plus i.
	task automatic load(logic [7:0] base);
		@(negedge clk);
		for (int i = 0; i < DATA_BYTES; i++)
			sample_in[i*8 +: 8] = base + 8'(i);
		sample_strobe = 1'b1;
		drdy_set = 3'b111;
		@(negedge clk);
		sample_strobe = 1'b0;
		drdy_set = '0;
	endtask

	task automatic t_ident();
		i_host.access(1'b1, ADDR_IDENT, 8'hFF, q, ok);
		i_host.access(1'b1, ADDR_POWER, 8'hFF, q, ok);
		rd(ADDR_IDENT, IDENT_VALUE);
		rd(ADDR_POWER, POWER_RESET);
		rd(8'h01, 8'h00);
		rd(8'h18, 8'h00);
	endtask

	// The fatal flag survives reads, so a second reset is the only way out.
	task automatic t_error();
		i_host.access(1'b1, ADDR_ERROR, 8'hFF, q, ok);
		rd(ADDR_ERROR, ERROR_RESET);
		ev('{1'b0, 1'b0, 1'b1, 4'h3});
		ev('{1'b1, 1'b0, 1'b1, 4'h6});
		rd(ADDR_ERROR, 8'h46);
		rd(ADDR_ERROR, 8'h00);
		ev('{1'b0, 1'b0, 1'b1, 4'h7});
		rd(ADDR_ERROR, 8'h0E);
		ev('{1'b0, 1'b1, 1'b0, 4'h0});
		rd(ADDR_ERROR, 8'h01);
		rd(ADDR_ERROR, 8'h01);
		reset_dut();
		rd(ADDR_ERROR, 8'h00);
	endtask

	task automatic t_power();
		mode_req = '{PM_LOW, PM_FAST, PM_NORMAL};
		rd(ADDR_POWER, POWER_RESET);
		eff(3'b010);
		rd(ADDR_POWER, 8'h0C);
		chk("fifo_blocked", 8'h00, {7'h00, fifo_blocked});
		eff(3'b101);
		rd(ADDR_POWER, 8'h2D);
		chk("fifo_blocked", 8'h01, {7'h00, fifo_blocked});
		mode_req = '{PM_NORMAL, PM_SUSPEND, PM_SUSPEND};
		eff(3'b111);
		rd(ADDR_POWER, 8'h10);
		chk("fifo_blocked", 8'h00, {7'h00, fifo_blocked});
		mode_req.gyr = PM_NORMAL;
		eff(3'b010);
		rd(ADDR_POWER, 8'h14);
	endtask

	task automatic t_data();
		load(8'h01);
		rd(ADDR_GYRO_LO, 8'h09);
		chk("drdy_flags", 8'h05, {5'h00, drdy_flags});
		rd(ADDR_ACCEL_LO, 8'h0F);
		rd(8'h05, 8'h02);
		chk("drdy_flags", 8'h00, {5'h00, drdy_flags});
		stab_mode = 1'b1;
		stab_addr = 4'h5;
		@(negedge clk);
		chk("stab_rdata", 8'h0E, stab_rdata);
		stab_addr = 4'h6;
		@(negedge clk);
		chk("stab_rdata", 8'h00, stab_rdata);
		stab_mode = 1'b0;
		for (int i = 0; i < DATA_BYTES; i++)
			rd(ADDR_DATA_LO + 8'(i), 8'(i + 1));
		access_active = 1'b1;
		rd(ADDR_DATA_LO, 8'h01);
		load(8'h41);
		rd(ADDR_DATA_HI, 8'h14);
		access_active = 1'b0;
		@(negedge clk);
		rd(ADDR_DATA_HI, 8'h54);
	endtask

	initial begin
		reset_dut();
		t_ident();
		t_error();
		t_power();
		t_data();
		report_and_stop();
	end
endmodule
